// file: logic/sdram_pkg.sv
// shared constants for the sdram pin interface: commands, geometry, mask timing
// assumes both ends include this package and share one clock
package sdram_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 2;
   localparam int MASK_W = 4;
   localparam int COL_W = 8;
   localparam int ROW_W = 12;
   localparam int LANE_W = 8;
   localparam int NUM_BANKS = 4;
   localparam int AP_BIT = 10;
   // read mask to high-z latency in clocks
   localparam int DQM_RD_LAT = 2;
   // mode register field positions
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_CL_LSB = 4;
   localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
   // command codes {ras_n, cas_n, we_n} with cs_n low
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // burst length codes
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
endpackage

// file: logic/sdram_if.sv
// pin bundle between the memory controller and the sdram device model
// resolves the data bus here from the two enables
`timescale 1ns/100ps
`default_nettype none
interface sdram_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [sdram_pkg::BANK_W-1:0] ba;
   logic [sdram_pkg::ADDR_W-1:0] addr;
   logic [sdram_pkg::MASK_W-1:0] dqm;
   logic [sdram_pkg::DATA_W-1:0] dq_ctl;
   logic dq_ctl_oe;
   logic [sdram_pkg::DATA_W-1:0] dq_mem;
   logic [sdram_pkg::MASK_W-1:0] dq_mem_oe;
   logic [sdram_pkg::DATA_W-1:0] dq;
   // resolved bus, driven here so neither end holds high impedance
   always_comb begin
      dq = '0;
      if (dq_ctl_oe) begin
         dq = dq_ctl;
      end
      for (int i = 0; i < sdram_pkg::MASK_W; i++) begin
         if (dq_mem_oe[i]) begin
            dq[i*8 +: 8] = dq_mem[i*8 +: 8];
         end
      end
   end
   modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl, dq_ctl_oe,
      input dq);
   modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
      output dq_mem, dq_mem_oe);
endinterface
`default_nettype wire

// file: logic/sdram_mem.sv
// sdram device end: command decoder, banks, burst engine, masks, power states
// assumes the pins come from logic on clk_in and are valid at its rising edge
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - all inputs sampled on rising clock edge
// - burst counter and outputs advance each edge
// - cke low gates clock into power states
// - cke still sampled on clock edge in power-down
// - inputs ignored during power-down or refresh
// - controller may tie cke high
// - commands decoded only when chip select low
// - bursts and masks continue when deselected
// - four strobes together encode command
// - masked write bytes keep old contents
// - read mask gives high-z two clocks later
// - mask bit n covers byte lane n
// - bank lines select command target bank
// - row on active, column on read/write
// - a10 selects auto precharge on access
// - a10 high on precharge closes all
// - mode register loaded from address lines
// - device drives data only in reads
// - burst lengths 1,2,4,8, page, terminate
// - row opened before read or write
// - four banks, 4096 rows, 256 columns
module sdram_mem #(
   parameter int MEM_WORDS = 256
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   sdram_if.mem pins,
   output logic powered_down_out,
   output logic [sdram_pkg::NUM_BANKS-1:0] bank_open_out
);
   typedef enum {ST_IDLE, ST_READ, ST_WRITE} burst_t;
   typedef enum {PW_RUN, PW_SUSPEND, PW_DOWN, PW_SELF} power_t;

   localparam int AW = $clog2(MEM_WORDS);

   // read word gathered from the four lane stores of the write path
   wire logic [sdram_pkg::DATA_W-1:0] rd_word;
   logic [sdram_pkg::ROW_W-1:0] open_row [sdram_pkg::NUM_BANKS];
   logic [sdram_pkg::ADDR_W-1:0] mode;
   burst_t burst;
   power_t power;
   logic [sdram_pkg::BANK_W-1:0] b_bank;
   logic [sdram_pkg::COL_W-1:0] b_col;
   logic [sdram_pkg::COL_W:0] b_left;
   logic b_auto;
   logic cke_q;
   logic [sdram_pkg::DATA_W-1:0] rd_pipe;
   logic rd_valid;
   logic [sdram_pkg::MASK_W-1:0] dqm_d1;
   logic active_clk;
   logic cmd_valid;
   logic [2:0] cmd;
   logic [sdram_pkg::COL_W:0] next_len;
   logic [AW-1:0] word_idx;

   ////////////////////////////////////////////////////////////////////////////////
   // clock gating and command decode

   // the clock counts only when cke was high at the previous edge and not asleep
   assign active_clk = cke_q && (power == PW_RUN);
   // chip select high masks the strobes; all four read together
   assign cmd_valid = active_clk && !pins.cs_n;
   assign cmd = {pins.ras_n, pins.cas_n, pins.we_n};

   always_comb begin
      case (mode[sdram_pkg::MODE_BL_LSB +: 3])
         sdram_pkg::BL_1: next_len = 9'h001;
         sdram_pkg::BL_2: next_len = 9'h002;
         sdram_pkg::BL_4: next_len = 9'h004;
         sdram_pkg::BL_8: next_len = 9'h008;
         default: next_len = 9'h100;
      endcase
   end

   assign word_idx = AW'({b_bank, open_row[b_bank][1:0], b_col});

   ////////////////////////////////////////////////////////////////////////////////
   // power states: cke taken low enters, cke high exits

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cke_q <= 1'b1;
         power <= PW_RUN;
      end else begin
         cke_q <= pins.cke;
         case (power)
            PW_RUN: begin
               if (cke_q && !pins.cke) begin
                  if (burst != ST_IDLE) begin
                     power <= PW_SUSPEND;
                  end else if (!pins.cs_n && cmd == sdram_pkg::CMD_REF) begin
                     power <= PW_SELF;
                  end else begin
                     power <= PW_DOWN;
                  end
               end
            end
            // while asleep only cke is watched, no other pin
            PW_SUSPEND, PW_DOWN, PW_SELF: begin
               if (pins.cke) begin
                  power <= PW_RUN;
               end
            end
            default: power <= PW_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bank state, mode register and burst engine

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         bank_open_out <= '0;
         mode <= sdram_pkg::MODE_RESET;
         burst <= ST_IDLE;
         b_bank <= '0;
         b_col <= '0;
         b_left <= '0;
         b_auto <= 1'b0;
         for (int i = 0; i < sdram_pkg::NUM_BANKS; i++) begin
            open_row[i] <= '0;
         end
      end else if (active_clk) begin
         // burst runs on regardless of chip select
         if (burst != ST_IDLE) begin
            b_col <= b_col + 8'h01;
            b_left <= b_left - 9'h001;
            if (b_left == 9'h001) begin
               burst <= ST_IDLE;
               if (b_auto) begin
                  bank_open_out[b_bank] <= 1'b0;
               end
            end
         end
         if (cmd_valid) begin
            case (cmd)
               sdram_pkg::CMD_MRS: mode <= pins.addr;
               sdram_pkg::CMD_ACT: begin
                  open_row[pins.ba] <= pins.addr;
                  bank_open_out[pins.ba] <= 1'b1;
               end
               sdram_pkg::CMD_PRE: begin
                  if (pins.addr[sdram_pkg::AP_BIT]) begin
                     bank_open_out <= '0;
                  end else begin
                     bank_open_out[pins.ba] <= 1'b0;
                  end
               end
               sdram_pkg::CMD_RD, sdram_pkg::CMD_WR: begin
                  // access assumes the bank row was opened first
                  burst <= (cmd == sdram_pkg::CMD_RD) ? ST_READ : ST_WRITE;
                  b_bank <= pins.ba;
                  b_col <= pins.addr[sdram_pkg::COL_W-1:0];
                  b_auto <= pins.addr[sdram_pkg::AP_BIT];
                  b_left <= next_len;
               end
               sdram_pkg::CMD_BST: burst <= ST_IDLE;
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write path with per-lane masking

   generate
      for (genvar g = 0; g < sdram_pkg::MASK_W; g++) begin : g_lane
         // one store per lane, a reduced window indexed by the low AW bits of bank, row and column, so by the column alone at 256 words
         logic [sdram_pkg::LANE_W-1:0] store [MEM_WORDS];
         always_ff @(posedge clk_in) begin
            // masked lanes leave the stored byte untouched
            if (active_clk && burst == ST_WRITE && !pins.dqm[g]) begin
               store[word_idx] <= pins.dq[g*8 +: 8];
            end
         end
         assign rd_word[g*8 +: 8] = store[word_idx];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // read path: two-stage output register, mask gates the bus two edges after sampling

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rd_pipe <= '0;
         rd_valid <= 1'b0;
         dqm_d1 <= '1;
      end else if (active_clk) begin
         rd_pipe <= rd_word;
         rd_valid <= (burst == ST_READ);
         dqm_d1 <= pins.dqm;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         pins.dq_mem <= '0;
         pins.dq_mem_oe <= '0;
         powered_down_out <= 1'b0;
      end else begin
         powered_down_out <= (power == PW_DOWN) || (power == PW_SELF);
         if (active_clk) begin
            pins.dq_mem <= rd_pipe;
            // drive only in read cycles, lanes gated by the delayed mask
            pins.dq_mem_oe <= rd_valid ? ~dqm_d1 : '0;
         end
      end
   end
endmodule
`default_nettype wire

// file: logic/sdram_ctl.sv
// memory controller end: issues one command per user request onto the pins
// assumes user requests come from logic on clk_in
`timescale 1ns/100ps
`default_nettype none
module sdram_ctl (
   input wire logic clk_in,
   input wire logic rstn_in,
   sdram_if.ctl pins,
   input wire logic req_in,
   input wire logic [2:0] cmd_in,
   input wire logic [sdram_pkg::BANK_W-1:0] bank_in,
   input wire logic [sdram_pkg::ADDR_W-1:0] addr_in,
   input wire logic [sdram_pkg::MASK_W-1:0] mask_in,
   input wire logic [sdram_pkg::DATA_W-1:0] wdata_in,
   input wire logic wdata_en_in,
   input wire logic cke_in,
   output logic [sdram_pkg::DATA_W-1:0] rdata_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // all pins registered so they are stable at the device's sampling edge

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         pins.cke <= 1'b1;
         pins.cs_n <= 1'b1;
         pins.ras_n <= 1'b1;
         pins.cas_n <= 1'b1;
         pins.we_n <= 1'b1;
         pins.ba <= '0;
         pins.addr <= '0;
         pins.dqm <= '1;
         pins.dq_ctl <= '0;
         pins.dq_ctl_oe <= 1'b0;
         rdata_out <= '0;
      end else begin
         pins.cke <= cke_in;
         // the four strobes move together; idle is deselect
         pins.cs_n <= !req_in;
         {pins.ras_n, pins.cas_n, pins.we_n} <= req_in ? cmd_in : sdram_pkg::CMD_NOP;
         pins.ba <= bank_in;
         pins.addr <= addr_in;
         pins.dqm <= mask_in;
         pins.dq_ctl <= wdata_in;
         pins.dq_ctl_oe <= wdata_en_in;
         rdata_out <= pins.dq;
      end
   end
endmodule
`default_nettype wire

// file: tb/sdram_chk.sv
// pin-level checks between the controller and device ends
// assumes one clock and the sdram_if signals wired in by name
`timescale 1ns/100ps
`default_nettype none
module sdram_chk (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [sdram_pkg::MASK_W-1:0] dqm,
   input wire logic [sdram_pkg::DATA_W-1:0] dq_ctl,
   input wire logic dq_ctl_oe,
   input wire logic [sdram_pkg::DATA_W-1:0] dq_mem,
   input wire logic [sdram_pkg::MASK_W-1:0] dq_mem_oe,
   input wire logic [sdram_pkg::DATA_W-1:0] dq
);
   ////////////////////////////////////////////////////////////////////////////////
   // a read command on the pins, qualified by cke at the same edge
   logic rd_cmd;
   assign rd_cmd = cke && !cs_n && ({ras_n, cas_n, we_n} == sdram_pkg::CMD_RD);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////////////////////////
   a_reset_idle_pins: assert property ($rose(rstn_in) |-> cs_n && cke && dqm == 4'hF)
      else $error("pins not idle after reset");
   a_bus_no_clash: assert property (dq_ctl_oe |-> dq_mem_oe == 4'h0)
      else $error("both ends drive the data bus");
   a_ctl_to_bus: assert property (dq_ctl_oe |-> dq == dq_ctl)
      else $error("write data not on bus");
   a_mem_lane_bus: assert property (dq_mem_oe[1] && !dq_ctl_oe |->
      dq[15:8] == dq_mem[15:8])
      else $error("lane 1 read data not on bus");
   a_mask_lane_low: assert property ((cke && dqm[0])[*2] |-> ##2 !dq_mem_oe[0])
      else $error("lane 0 driven under mask");
   a_mask_lane_high: assert property ((cke && dqm[3])[*2] |-> ##2 !dq_mem_oe[3])
      else $error("lane 3 driven under mask");
   a_lanes_whole: assert property ((cke && dqm == 4'h0)[*2] ##2 (|dq_mem_oe) |->
      &dq_mem_oe)
      else $error("unmasked read lane left off");
   a_read_origin: assert property ($rose(|dq_mem_oe) |->
      $past(rd_cmd, 2) || $past(rd_cmd, 3) || $past(rd_cmd, 4))
      else $error("device drove bus without read");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench: controller and device joined by sdram_if
// assumes a 100 MHz clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic req_in = 1'b0;
   logic [2:0] cmd_in = 3'h7;
   logic [1:0] bank_in = 2'h0;
   logic [11:0] addr_in = 12'h000;
   logic [3:0] mask_in = 4'h0;
   logic [31:0] wdata_in = 32'h00000000;
   logic wdata_en_in = 1'b0;
   logic cke_in = 1'b1;
   logic [31:0] rdata_out;
   logic powered_down_out;
   logic [3:0] bank_open_out;
   int err_total = 0;
   int samples_checked = 0;
   int n;
   ////////////////////////////////////////////////////////////////////////////////
   // both ends, the bus between them and its checker
   sdram_if bus();
   sdram_ctl sdram_ctl_inst (.clk_in(clk_in), .rstn_in(rstn_in), .pins(bus.ctl),
      .req_in(req_in), .cmd_in(cmd_in), .bank_in(bank_in), .addr_in(addr_in),
      .mask_in(mask_in), .wdata_in(wdata_in), .wdata_en_in(wdata_en_in), .cke_in(cke_in),
      .rdata_out(rdata_out));
   sdram_mem #(.MEM_WORDS(256)) sdram_mem_inst (.clk_in(clk_in), .rstn_in(rstn_in),
      .pins(bus.mem), .powered_down_out(powered_down_out), .bank_open_out(bank_open_out));
   sdram_chk sdram_chk_inst (.clk_in(clk_in), .rstn_in(rstn_in), .cke(bus.cke),
      .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .dqm(bus.dqm),
      .dq_ctl(bus.dq_ctl), .dq_ctl_oe(bus.dq_ctl_oe), .dq_mem(bus.dq_mem),
      .dq_mem_oe(bus.dq_mem_oe), .dq(bus.dq));
   // 100 MHz clock
   always #5 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   // one request, write data in the following cycle
   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
      input logic [3:0] m, input logic [31:0] d, input logic w);
      @(negedge clk_in);
      req_in = 1'b1;
      cmd_in = c;
      bank_in = b;
      addr_in = a;
      mask_in = m;
      @(negedge clk_in);
      req_in = 1'b0;
      wdata_in = d;
      wdata_en_in = w;
      @(negedge clk_in);
      wdata_en_in = 1'b0;
   endtask
   task automatic wait_banks(input logic [3:0] exp);
      for (n = 0; n < 10 && bank_open_out !== exp; n++)
         @(negedge clk_in);
      chk(bank_open_out === exp, "bank open flags");
   endtask
   task automatic rd(input logic [11:0] a, input logic [3:0] m, input logic [31:0] exp);
      cmd(sdram_pkg::CMD_RD, 2'h0, a, m, 32'h00000000, 1'b0);
      for (n = 0; n < 8 && rdata_out !== exp; n++)
         @(negedge clk_in);
      chk(rdata_out === exp, "read data");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_open();
      for (int b = 0; b < 4; b++) begin
         cmd(sdram_pkg::CMD_ACT, b[1:0], 12'h003, 4'h0, 32'h00000000, 1'b0);
         wait_banks((4'h2 << b) - 4'h1);
      end
   endtask
   task automatic t_write_mask();
      cmd(sdram_pkg::CMD_WR, 2'h0, 12'h005, 4'h0, 32'h11223344, 1'b1);
      cmd(sdram_pkg::CMD_WR, 2'h0, 12'h005, 4'h5, 32'hAABBCCDD, 1'b1);
      rd(12'h005, 4'h0, 32'hAA22CC44);
   endtask
   task automatic t_read_mask();
      for (int i = 0; i < 4; i++) begin
         rd(12'h005, 4'h1 << i, 32'hAA22CC44 & ~(32'h000000FF << (8 * i)));
      end
   endtask
   task automatic t_auto_pre();
      cmd(sdram_pkg::CMD_WR, 2'h1, 12'h400, 4'h0, 32'h5A5A5A5A, 1'b1);
      wait_banks(4'hD);
   endtask
   task automatic t_precharge();
      cmd(sdram_pkg::CMD_PRE, 2'h2, 12'h000, 4'h0, 32'h00000000, 1'b0);
      wait_banks(4'h9);
      cmd(sdram_pkg::CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h00000000, 1'b0);
      wait_banks(4'h0);
   endtask
   task automatic t_power();
      @(negedge clk_in);
      cke_in = 1'b0;
      for (n = 0; n < 6 && powered_down_out !== 1'b1; n++)
         @(negedge clk_in);
      chk(powered_down_out === 1'b1, "no power-down");
      cmd(sdram_pkg::CMD_ACT, 2'h3, 12'h001, 4'h0, 32'h00000000, 1'b0);
      repeat (4) @(negedge clk_in);
      chk(bank_open_out === 4'h0, "command taken while asleep");
      cke_in = 1'b1;
      for (n = 0; n < 6 && powered_down_out !== 1'b0; n++)
         @(negedge clk_in);
      chk(powered_down_out === 1'b0, "no wake-up");
      cmd(sdram_pkg::CMD_ACT, 2'h3, 12'h001, 4'h0, 32'h00000000, 1'b0);
      wait_banks(4'h8);
   endtask
   // two-word burst after a mode load, read back while deselected
   task automatic t_burst();
      cmd(sdram_pkg::CMD_WR, 2'h3, 12'h008, 4'h0, 32'h01020304, 1'b1);
      cmd(sdram_pkg::CMD_WR, 2'h3, 12'h009, 4'h0, 32'h05060708, 1'b1);
      cmd(sdram_pkg::CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h00000000, 1'b0);
      cmd(sdram_pkg::CMD_MRS, 2'h0, 12'h021, 4'h0, 32'h00000000, 1'b0);
      cmd(sdram_pkg::CMD_ACT, 2'h3, 12'h001, 4'h0, 32'h00000000, 1'b0);
      cmd(sdram_pkg::CMD_RD, 2'h3, 12'h008, 4'h0, 32'h00000000, 1'b0);
      for (n = 0; n < 8 && rdata_out !== 32'h01020304; n++)
         @(negedge clk_in);
      chk(rdata_out === 32'h01020304, "first burst word");
      @(negedge clk_in);
      chk(rdata_out === 32'h05060708, "second burst word");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence after five reset cycles
   initial begin
      repeat (5) @(negedge clk_in);
      rstn_in = 1'b1;
      t_open();
      t_write_mask();
      t_read_mask();
      t_auto_pre();
      t_precharge();
      t_power();
      t_burst();
      print_verdict();
   end
   // watchdog well past the expected run
   initial begin
      repeat (2000) @(posedge clk_in);
      err_total++;
      $display("wrong value at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule
`default_nettype wire
